// [src/opk_pkg.sv]
// constants and types for the operator panel indicator and key logic
// assumes a single 50 MHz clock and a synchronous active-high reset
// Notes on behaviour
// - uplink activity lamp lights on first uplink character arriving
// - no attitude lamp when operating without inertial reference
// - key release lamp set on display clash or key over display
// - key release lamp cleared by release key or normal commit
// - operator error lamp lights on an improper key sequence
// - thermal warning lamp lights while in-range temperature signal absent
// - gimbal lock lamp lights beyond plus or minus 70 degrees
// - beyond 85 degrees command coarse align; no attitude lamp follows
// - software alarm lamp lights whenever a program alarm occurs
// - restart latch lights restart lamp until alarm reset key pressed
// - tracker lamp on resolver failure in auto without zeroing, or fewer than N good samples in 2N tries
// - height fault lamp on missing range-good while reading range, or bad range scaling
// - speed fault lamp on missing velocity-good while reading velocity
// - computer busy lamp lights during an internal sequence
// - display of 24 sections: digits or blank, signs plus minus blank
// - three five-digit data rows and verb, noun, program fields
// - after verb or noun key, next two digits form that code
// - clear key blanks the data row being loaded
// - advance key in standby selects operate and routine 00
// - advance key in idle state: proceed, or standby when program 06
// - commit key executes verb noun, accepts load, or answers request
// - alarm reset clears only alarms whose condition is corrected
`default_nettype none

package opk_pkg;
  localparam int          OPK_CLK_HZ        = 50_000_000;
  localparam logic [3:0]  OPK_BLANK         = 4'hF;  // blank digit code
  localparam logic [1:0]  OPK_SIGN_BLANK    = 2'h0;
  localparam logic [1:0]  OPK_SIGN_PLUS     = 2'h1;
  localparam logic [1:0]  OPK_SIGN_MINUS    = 2'h2;
  localparam int          OPK_ROW_DIGITS    = 5;
  localparam int          OPK_ROWS          = 3;
  localparam int          OPK_CODE_DIGITS   = 2;
  localparam logic [7:0]  OPK_GIMBAL_WARN   = 8'h46; // 70 degrees
  localparam logic [7:0]  OPK_GIMBAL_ALIGN  = 8'h55; // 85 degrees
  localparam logic [7:0]  OPK_SOFTWARE_ALARM_LAMP_STANDBY  = 8'h06; // program 06, bcd
  localparam logic [7:0]  OPK_ROUTINE_IDLE  = 8'h00; // routine 00, bcd
  localparam logic [7:0]  OPK_CODE_RESET    = 8'hFF; // blank code pair
  localparam int          OPK_RESTORE_NS    = 1000;  // clock restore time
  localparam int          OPK_RESTORE_CYC   =
    (OPK_RESTORE_NS * (OPK_CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [5:0] {
    OPK_IDLE    = 6'b000001,
    OPK_VERB    = 6'b000010,
    OPK_NOUN    = 6'b000100,
    OPK_LOAD    = 6'b001000,
    OPK_RESTORE = 6'b010000,
    OPK_STANDBY = 6'b100000
  } opk_state_t;

  typedef enum logic [3:0] {
    OPK_K_NONE   = 4'h0,
    OPK_K_VERB   = 4'h1,
    OPK_K_NOUN   = 4'h2,
    OPK_K_PLUS   = 4'h3,
    OPK_K_MINUS  = 4'h4,
    OPK_K_CLEAR  = 4'h5,
    OPK_K_ADV    = 4'h6,
    OPK_K_COMMIT = 4'h7,
    OPK_K_RESET  = 4'h8,
    OPK_K_REL    = 4'h9,
    OPK_K_DIGIT  = 4'hA
  } opk_key_t;

  // magnitude of a signed angle in degrees
  function automatic logic [7:0] opk_abs(input logic signed [8:0] a);
    opk_abs = a[8] ? 8'(-a) : a[7:0];
  endfunction
endpackage : opk_pkg

`default_nettype wire

// [src/opk_sync.sv]
// three-stage synchroniser bank for asynchronous status inputs
// assumes one clock; a change counts once stages two and three agree
`default_nettype none

module opk_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  initial begin
    if (WIDTH < 1) $error("opk_sync width must be positive");
  end

  // first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept a bit only where the last two stages agree
  always_ff @(posedge clock) begin
    if (rst) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) dout[i] <= s3_r[i];
      end
    end
  end
endmodule : opk_sync

`default_nettype wire

// [src/opk_panel.sv]
// top of the operator panel: lamps, key sequencing and display fields
// assumes status bits from the computer and keys from the crew panel
`default_nettype none

module opk_panel
  import opk_pkg::*;
#(
  parameter int          NSAMP   = 8,
  parameter int          RESTORE = OPK_RESTORE_CYC
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              key_strobe,
  input  wire logic [3:0]        key_code,
  input  wire logic [3:0]        key_digit,
  input  wire logic              uplink_char,
  input  wire logic              uplink_msg_end,
  input  wire logic              iss_on,
  input  wire logic              iss_caged,
  input  wire logic              iss_coarse,
  input  wire logic              temp_in_range,
  input  wire logic signed [8:0] middle_gimbal,
  input  wire logic              software_alarm_lamp_alarm,
  input  wire logic              restart_event,
  input  wire logic              rr_on,
  input  wire logic              lr_on,
  input  wire logic              rr_resolver_fail,
  input  wire logic              rr_auto,
  input  wire logic              rr_zeroing,
  input  wire logic              radar_try,
  input  wire logic              radar_sample_ok,
  input  wire logic              lr_reading_range,
  input  wire logic              lr_range_good,
  input  wire logic              lr_range_scale_bad,
  input  wire logic              lr_reading_vel,
  input  wire logic              lr_vel_good,
  input  wire logic              internal_busy,
  input  wire logic              internal_display,
  input  wire logic              internal_flash,
  input  wire logic              monitor_active,
  input  wire logic              please_perform,
  input  wire logic [7:0]        program_code,
  output logic                   uplink_activity_lamp,
  output logic                   no_attitude_lamp,
  output logic                   standby_lamp,
  output logic                   key_release,
  output logic                   operator_error_lamp,
  output logic                   thermal_warning_lamp,
  output logic                   gimbal_lock_lamp,
  output logic                   software_alarm_lamp,
  output logic                   restart_lamp,
  output logic                   tracker_lamp,
  output logic                   height_fault_lamp,
  output logic                   speed_fault_lamp,
  output logic                   computer_busy_lamp,
  output logic                   coarse_align_cmd,
  output logic                   proceed_pulse,
  output logic                   execute_pulse,
  output logic                   accept_pulse,
  output logic                   perform_ack_pulse,
  output logic                   routine_select,
  output logic [7:0]             verb_code,
  output logic [7:0]             noun_code,
  output logic [7:0]             software_alarm_lamp_field,
  output logic [59:0]            data_digits,
  output logic [5:0]             data_signs
);
  localparam int NS = 20;
  localparam int CW = $clog2(2 * NSAMP + 1);
  localparam int RW = $clog2(RESTORE + 1);

  initial begin
    if (NSAMP < 1) $error("NSAMP must be at least one");
    if (RESTORE < 1) $error("RESTORE must be at least one");
  end

  logic [NS-1:0] st;
  opk_sync #(.WIDTH(NS)) u_sync (
    .clock (clock),
    .rst   (rst),
    .din   ({uplink_char, uplink_msg_end, iss_on, iss_caged, iss_coarse,
             temp_in_range, software_alarm_lamp_alarm, restart_event, rr_on, lr_on,
             rr_resolver_fail, rr_auto, rr_zeroing, lr_reading_range,
             lr_range_good, lr_range_scale_bad, lr_reading_vel,
             lr_vel_good, internal_busy, internal_display}),
    .dout  (st)
  );
  logic s_upc, s_upe, s_isson, s_cage, s_coarse, s_temp, s_alarm;
  logic s_rst_ev, s_rron, s_lron, s_rrfail, s_rrauto, s_rrzero;
  logic s_lrrng, s_lrrgood, s_lrscale, s_lrvel, s_lrvgood, s_busy, s_idisp;
  assign {s_upc, s_upe, s_isson, s_cage, s_coarse, s_temp, s_alarm,
          s_rst_ev, s_rron, s_lron, s_rrfail, s_rrauto, s_rrzero, s_lrrng,
          s_lrrgood, s_lrscale, s_lrvel, s_lrvgood, s_busy, s_idisp} = st;

  opk_state_t state_r;
  logic [7:0] gabs;
  logic       operate;
  logic       restart_r;
  logic       prev_upc_r;
  logic       prev_idisp_r;
  logic [CW-1:0] tries_r;
  logic [CW-1:0] good_r;
  logic       track_miss_r;
  logic [1:0] dcnt_r;
  logic [1:0] row_r;
  logic [2:0] dpos_r;
  logic [RW-1:0] rcnt_r;
  logic       key_held_r;

  assign gabs    = opk_abs(middle_gimbal);
  assign operate = (state_r != OPK_STANDBY) && (state_r != OPK_RESTORE);

  wire k_dig    = key_strobe && key_code == OPK_K_DIGIT;
  wire k_verb   = key_strobe && key_code == OPK_K_VERB;
  wire k_noun   = key_strobe && key_code == OPK_K_NOUN;
  wire k_sign   = key_strobe &&
                  (key_code == OPK_K_PLUS || key_code == OPK_K_MINUS);
  wire k_clear  = key_strobe && key_code == OPK_K_CLEAR;
  wire k_adv    = key_strobe && key_code == OPK_K_ADV;
  wire k_commit = key_strobe && key_code == OPK_K_COMMIT;
  wire k_reset  = key_strobe && key_code == OPK_K_RESET;
  wire k_rel    = key_strobe && key_code == OPK_K_REL;
  wire k_bad    = key_strobe && key_code > OPK_K_DIGIT;
  wire in_prog6 = program_code == OPK_SOFTWARE_ALARM_LAMP_STANDBY;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= OPK_IDLE;
      dcnt_r  <= 2'h0;
      rcnt_r  <= '0;
    end else begin
      unique case (state_r)
        OPK_IDLE: begin
          dcnt_r <= 2'h0;
          if (k_verb) state_r <= OPK_VERB;
          else if (k_noun) state_r <= OPK_NOUN;
          else if (k_adv && in_prog6) state_r <= OPK_STANDBY;
          else if (k_commit && verb_code[7:4] >= 4'h2 &&
                   verb_code[7:4] <= 4'h2) state_r <= OPK_LOAD;
        end
        OPK_VERB, OPK_NOUN: begin
          if (k_dig) begin
            dcnt_r <= dcnt_r + 2'h1;
            if (dcnt_r == 2'(OPK_CODE_DIGITS - 1)) state_r <= OPK_IDLE;
          end else if (k_commit || k_rel) begin
            state_r <= OPK_IDLE;
          end
        end
        OPK_LOAD: begin
          if (k_commit && row_r == 2'(OPK_ROWS - 1)) state_r <= OPK_IDLE;
          else if (k_rel) state_r <= OPK_IDLE;
        end
        OPK_STANDBY: begin
          rcnt_r <= '0;
          if (k_adv) state_r <= OPK_RESTORE;
        end
        OPK_RESTORE: begin
          rcnt_r <= rcnt_r + RW'(1);
          if (rcnt_r == RW'(RESTORE - 1)) state_r <= OPK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      verb_code <= OPK_CODE_RESET;
      noun_code <= OPK_CODE_RESET;
    end else if (k_dig && state_r == OPK_VERB) begin
      if (dcnt_r == 2'h0) verb_code <= {key_digit, OPK_BLANK};
      else verb_code <= {verb_code[7:4], key_digit};
    end else if (k_dig && state_r == OPK_NOUN) begin
      if (dcnt_r == 2'h0) noun_code <= {key_digit, OPK_BLANK};
      else noun_code <= {noun_code[7:4], key_digit};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      data_digits <= {(OPK_ROWS * OPK_ROW_DIGITS){OPK_BLANK}};
      data_signs  <= {OPK_ROWS{OPK_SIGN_BLANK}};
      row_r       <= 2'h0;
      dpos_r      <= 3'h0;
    end else if (state_r != OPK_LOAD) begin
      row_r  <= 2'h0;
      dpos_r <= 3'h0;
    end else if (k_clear) begin
      data_digits[row_r*20 +: 20] <= {OPK_ROW_DIGITS{OPK_BLANK}};
      data_signs[row_r*2 +: 2]    <= OPK_SIGN_BLANK;
      dpos_r                      <= 3'h0;
    end else if (k_sign) begin
      data_signs[row_r*2 +: 2] <= (key_code == OPK_K_PLUS) ?
                                  OPK_SIGN_PLUS : OPK_SIGN_MINUS;
    end else if (k_dig && dpos_r < 3'(OPK_ROW_DIGITS)) begin
      data_digits[row_r*20 + (4 - dpos_r)*4 +: 4] <= key_digit;
      dpos_r <= dpos_r + 3'h1;
    end else if (k_commit && row_r != 2'(OPK_ROWS - 1)) begin
      row_r  <= row_r + 2'h1;
      dpos_r <= 3'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      proceed_pulse     <= 1'b0;
      execute_pulse     <= 1'b0;
      accept_pulse      <= 1'b0;
      perform_ack_pulse <= 1'b0;
      routine_select    <= 1'b0;
    end else begin
      proceed_pulse     <= k_adv && state_r == OPK_IDLE && !in_prog6;
      execute_pulse     <= k_commit && state_r != OPK_LOAD &&
                           operate && !please_perform;
      accept_pulse      <= k_commit && state_r == OPK_LOAD;
      perform_ack_pulse <= k_commit && please_perform &&
                           state_r == OPK_IDLE;
      routine_select    <= state_r == OPK_RESTORE &&
                           rcnt_r == RW'(RESTORE - 1);
    end
  end

  // program field shows routine 00 while restoring, program_code otherwise
  always_ff @(posedge clock) begin
    if (rst) software_alarm_lamp_field <= OPK_CODE_RESET;
    else if (state_r == OPK_RESTORE) software_alarm_lamp_field <= OPK_ROUTINE_IDLE;
    else software_alarm_lamp_field <= program_code;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      operator_error_lamp <= 1'b0;
    end else if (k_bad ||
                 (k_sign && state_r != OPK_LOAD) ||
                 (k_clear && state_r != OPK_LOAD && state_r != OPK_IDLE)) begin
      operator_error_lamp <= 1'b1;
    end else if (k_reset) begin
      operator_error_lamp <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      key_held_r   <= 1'b0;
      key_release  <= 1'b0;
      prev_idisp_r <= 1'b0;
    end else begin
      prev_idisp_r <= s_idisp;
      if (state_r != OPK_IDLE) key_held_r <= 1'b1;
      else if (k_commit || k_rel) key_held_r <= 1'b0;
      if ((s_idisp && !prev_idisp_r && key_held_r) ||
          (key_strobe && !k_rel && (internal_flash || monitor_active)))
        key_release <= 1'b1;
      else if (k_rel || (k_commit && (internal_flash ||
               (state_r == OPK_LOAD && row_r == 2'(OPK_ROWS - 1)) ||
               verb_code[7:4] >= 4'h4)))
        key_release <= 1'b0;
    end
  end

  // restart latch, event wins over reset key
  always_ff @(posedge clock) begin
    if (rst) restart_r <= 1'b0;
    else if (s_rst_ev && operate) restart_r <= 1'b1;
    else if (k_reset) restart_r <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (rst || !(s_rron || s_lron)) begin
      tries_r      <= '0;
      good_r       <= '0;
      track_miss_r <= 1'b0;
    end else if (radar_try) begin
      if (tries_r == CW'(2 * NSAMP - 1)) begin
        track_miss_r <= (good_r + CW'(radar_sample_ok)) < CW'(NSAMP);
        tries_r      <= '0;
        good_r       <= '0;
      end else begin
        tries_r <= tries_r + CW'(1);
        good_r  <= good_r + CW'(radar_sample_ok);
      end
    end
  end

  // uplink lamp from first character to message end
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_upc_r           <= 1'b0;
      uplink_activity_lamp <= 1'b0;
    end else begin
      prev_upc_r <= s_upc;
      if (s_upc && !prev_upc_r) uplink_activity_lamp <= 1'b1;
      else if (s_upe) uplink_activity_lamp <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      no_attitude_lamp     <= 1'b0;
      standby_lamp         <= 1'b0;
      thermal_warning_lamp <= 1'b0;
      gimbal_lock_lamp     <= 1'b0;
      coarse_align_cmd     <= 1'b0;
      software_alarm_lamp  <= 1'b0;
      restart_lamp         <= 1'b0;
      tracker_lamp         <= 1'b0;
      height_fault_lamp    <= 1'b0;
      speed_fault_lamp     <= 1'b0;
      computer_busy_lamp   <= 1'b0;
    end else begin
      no_attitude_lamp     <= operate && (!s_isson || s_cage || s_coarse ||
                                          coarse_align_cmd);
      standby_lamp         <= state_r == OPK_STANDBY;
      thermal_warning_lamp <= !s_temp;
      gimbal_lock_lamp     <= gabs > OPK_GIMBAL_WARN;
      coarse_align_cmd     <= gabs > OPK_GIMBAL_ALIGN;
      software_alarm_lamp  <= s_alarm;
      restart_lamp         <= restart_r;
      tracker_lamp         <= (s_rron || s_lron) &&
                              ((s_rrfail && s_rrauto && !s_rrzero) ||
                               track_miss_r);
      height_fault_lamp    <= (s_lrrng && !s_lrrgood) || s_lrscale;
      speed_fault_lamp     <= s_lrvel && !s_lrvgood;
      computer_busy_lamp   <= s_busy;
    end
  end
endmodule : opk_panel

`default_nettype wire

// [tb/opk_panel_props.sv]
// assertion checker for the operator panel top module
// assumes it is bound onto opk_panel and sees only its ports
`default_nettype none

module opk_panel_props
  import opk_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              key_strobe,
  input wire logic [3:0]        key_code,
  input wire logic [3:0]        key_digit,
  input wire logic              uplink_char,
  input wire logic              temp_in_range,
  input wire logic signed [8:0] middle_gimbal,
  input wire logic              software_alarm_lamp_alarm,
  input wire logic [7:0]        program_code,
  input wire logic              uplink_activity_lamp,
  input wire logic              standby_lamp,
  input wire logic              operator_error_lamp,
  input wire logic              thermal_warning_lamp,
  input wire logic              gimbal_lock_lamp,
  input wire logic              software_alarm_lamp,
  input wire logic              restart_lamp,
  input wire logic              coarse_align_cmd,
  input wire logic              proceed_pulse,
  input wire logic [7:0]        verb_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // key kinds seen on the strobe
  sequence verb_key_s; key_strobe && key_code == 4'h1; endsequence
  sequence digit_s; key_strobe && key_code == 4'hA; endsequence
  sequence adv_op_s; key_strobe && key_code == 4'h6 && !standby_lamp;
  endsequence

  verb_digits_a: assert property (verb_key_s ##1 digit_s ##1 digit_s
    |=> verb_code == {$past(key_digit, 2), $past(key_digit)})
    else $error("verb code not built from two digits");
  bad_key_a: assert property (key_strobe && key_code >= 4'hB
    |=> operator_error_lamp) else $error("illegal key left no error");
  error_hold_a: assert property (operator_error_lamp &&
    !(key_strobe && key_code == 4'h8) |=> operator_error_lamp)
    else $error("error lamp dropped by itself");
  // lamp trails the latch by a cycle, so the key one cycle back counts
  restart_hold_a: assert property (restart_lamp &&
    !$past(key_strobe && key_code == 4'h8) |=> restart_lamp)
    else $error("restart latch dropped by itself");
  gimbal_warn_a: assert property ((middle_gimbal > 70 ||
    middle_gimbal < -70) |-> ##[1:2] gimbal_lock_lamp)
    else $error("gimbal lock lamp missing");
  coarse_cmd_a: assert property ((middle_gimbal > 85 ||
    middle_gimbal < -85) |-> ##[1:2] coarse_align_cmd)
    else $error("coarse align not commanded");
  thermal_lamp_a: assert property (!temp_in_range [*7]
    |-> thermal_warning_lamp) else $error("thermal lamp missing");
  alarm_lamp_a: assert property (software_alarm_lamp_alarm [*7]
    |-> software_alarm_lamp) else $error("software alarm lamp missing");
  uplink_lamp_a: assert property ($rose(uplink_char)
    |-> ##[3:7] uplink_activity_lamp) else $error("uplink lamp missing");
  standby_go_a: assert property (adv_op_s and
    program_code == 8'h06 |-> ##[1:3] standby_lamp)
    else $error("standby not entered");
  proceed_go_a: assert property (adv_op_s and
    program_code != 8'h06 |-> ##[1:2] proceed_pulse)
    else $error("proceed pulse missing");
endmodule // opk_panel_props

bind opk_panel opk_panel_props chk_u (.*);

`default_nettype wire

// [tb/opk_computer_model.sv]
// model of the computer's inertial and radar status logic
// assumes one clock shared with the panel; tries come every 4 cycles
`default_nettype none

module opk_computer_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic coarse_align_cmd,
  input  wire logic iss_power,
  input  wire logic radar_bad,
  output logic      iss_on,
  output logic      iss_caged,
  output logic      iss_coarse,
  output logic      radar_try,
  output logic      radar_sample_ok,
  output logic      rr_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] try_cnt_r;

  assign iss_on = iss_power;
  assign iss_caged = 1'b0;
  assign rr_on = 1'b1;
  always_ff @(posedge clock) begin
    iss_coarse <= !rst && coarse_align_cmd;
  end
  always_ff @(posedge clock) begin
    try_cnt_r <= rst ? 2'h0 : try_cnt_r + 2'h1;
  end
  assign radar_try = (try_cnt_r == 2'h3);
  // quality line toggles when no try is offered
  assign radar_sample_ok = radar_try ? !radar_bad : try_cnt_r[0];
endmodule // opk_computer_model

`default_nettype wire

// [tb/opk_panel_tb_top.sv]
// self-checking bench for the operator panel top
// assumes the computer model supplies inertial and radar status
`default_nettype none

module opk_panel_tb_top
  import opk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, key_strobe = 0, uplink_char = 0;
  logic [3:0] key_code = 0, key_digit = 0;
  logic uplink_msg_end = 0, temp_in_range = 1, software_alarm_lamp_alarm = 0;
  logic restart_event = 0, lr_on = 0, rr_resolver_fail = 0, rr_auto = 0;
  logic rr_zeroing = 0, lr_reading_range = 0, lr_range_good = 1;
  logic lr_range_scale_bad = 0, lr_reading_vel = 0, lr_vel_good = 1;
  logic internal_busy = 0, internal_display = 0, internal_flash = 0;
  logic monitor_active = 0, please_perform = 0, iss_power = 1;
  logic radar_bad = 0;
  logic signed [8:0] middle_gimbal = 0;
  logic [7:0] program_code = 0, verb_code, noun_code, software_alarm_lamp_field;
  logic iss_on, iss_caged, iss_coarse, radar_try, radar_sample_ok, rr_on;
  logic uplink_activity_lamp, no_attitude_lamp, standby_lamp, key_release;
  logic operator_error_lamp, thermal_warning_lamp, gimbal_lock_lamp;
  logic software_alarm_lamp, restart_lamp, tracker_lamp, height_fault_lamp;
  logic speed_fault_lamp, computer_busy_lamp, coarse_align_cmd;
  logic proceed_pulse, execute_pulse, accept_pulse, perform_ack_pulse;
  logic routine_select;
  logic [59:0] data_digits;
  logic [5:0] data_signs;
  int errors = 0, cmp_count = 0, cyc = 0;
  int n_exe = 0, n_acc = 0, n_pro = 0, n_rte = 0, n_ack = 0;
  logic signed [8:0] gim_v [7] = '{70, 71, -71, 85, 86, -86, 0};
  logic [1:0] gim_e [7] = '{0, 2, 2, 2, 3, 3, 0};

  opk_panel #(.NSAMP(2), .RESTORE(2)) dut_u (.*);
  opk_computer_model mdl_u (.*);

  always #10 clock = ~clock;

  // pulse counting and hang guard
  always @(posedge clock) begin
    n_exe += (execute_pulse === 1'b1);
    n_acc += (accept_pulse === 1'b1);
    n_pro += (proceed_pulse === 1'b1);
    n_rte += (routine_select === 1'b1);
    n_ack += (perform_ack_pulse === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic key(input logic [3:0] c, input logic [3:0] d = 0);
    key_strobe <= 1'b1;
    key_code <= c;
    key_digit <= d;
    @(posedge clock);
  endtask

  task automatic w(input int n);
    key_strobe <= 1'b0;
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input string nm, input logic [59:0] e,
                     input logic [59:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    w(1);
    chk("digits", {60{1'b1}}, data_digits);
    chk("verb", 8'hFF, verb_code);
    key(1);
    key(10, 3);
    key(10, 7);
    key(2);
    key(10, 1);
    key(10, 2);
    w(2);
    chk("verb", 8'h37, verb_code);
    chk("noun", 8'h12, noun_code);
    key(7);
    w(3);
    chk("exec", 1, n_exe);
    // load, clear and commit; entering the load also executes
    key(1);
    key(10, 2);
    key(10, 1);
    key(7);
    for (int i = 1; i <= 6; i++) key(10, 4'(i));
    key(3);
    w(2);
    chk("row0", 20'h12345, data_digits[19:0]);
    chk("sign0", OPK_SIGN_PLUS, data_signs[1:0]);
    internal_display <= 1'b1;
    w(8);
    chk("keyrel", 1, key_release);
    key(5);
    w(2);
    chk("row0", 20'hFFFFF, data_digits[19:0]);
    internal_display <= 1'b0;
    // each of the three row commits accepts one word
    repeat (3) key(7);
    w(3);
    chk("accept", 3, n_acc);
    chk("keyrel", 0, key_release);
    internal_flash <= 1'b1;
    key(1);
    w(2);
    chk("keyrel", 1, key_release);
    internal_flash <= 1'b0;
    key(9);
    w(2);
    chk("keyrel", 0, key_release);
    monitor_active <= 1'b1;
    key(2);
    w(2);
    chk("keyrel", 1, key_release);
    monitor_active <= 1'b0;
    key(9);
    key(10, 0);
    key(10, 6);
    w(2);
    chk("keyrel", 0, key_release);
    chk("noun", 8'h12, noun_code);
    key(11);
    w(2);
    chk("operr", 1, operator_error_lamp);
    key(8);
    key(4);
    w(2);
    chk("operr", 1, operator_error_lamp);
    key(8);
    w(2);
    chk("operr", 0, operator_error_lamp);
    temp_in_range <= 0;
    software_alarm_lamp_alarm <= 1;
    internal_busy <= 1;
    lr_reading_range <= 1;
    lr_range_good <= 0;
    lr_reading_vel <= 1;
    lr_vel_good <= 0;
    uplink_char <= 1;
    iss_power <= 0;
    w(8);
    key(8);
    w(8);
    chk("lamps", 7'h7F, {uplink_activity_lamp, no_attitude_lamp,
      thermal_warning_lamp, software_alarm_lamp, height_fault_lamp,
      speed_fault_lamp, computer_busy_lamp});
    temp_in_range <= 1;
    software_alarm_lamp_alarm <= 0;
    internal_busy <= 0;
    lr_range_good <= 1;
    lr_range_scale_bad <= 1;
    lr_vel_good <= 1;
    uplink_msg_end <= 1;
    iss_power <= 1;
    w(8);
    chk("lamps", 7'h04, {uplink_activity_lamp, no_attitude_lamp,
      thermal_warning_lamp, software_alarm_lamp, height_fault_lamp,
      speed_fault_lamp, computer_busy_lamp});
    restart_event <= 1;
    w(6);
    restart_event <= 0;
    w(8);
    chk("restart", 1, restart_lamp);
    key(8);
    w(2);
    chk("restart", 0, restart_lamp);
    for (int i = 0; i < 7; i++) begin
      middle_gimbal <= gim_v[i];
      w(8);
      chk("gimbal", gim_e[i], {gimbal_lock_lamp, coarse_align_cmd});
      if (i == 5) chk("noatt", 1, no_attitude_lamp);
    end
    rr_resolver_fail <= 1;
    rr_auto <= 1;
    rr_zeroing <= 1;
    w(8);
    chk("tracker", 0, tracker_lamp);
    rr_zeroing <= 0;
    w(8);
    chk("tracker", 1, tracker_lamp);
    rr_resolver_fail <= 0;
    w(8);
    chk("tracker", 0, tracker_lamp);
    radar_bad <= 1;
    w(40);
    chk("tracker", 1, tracker_lamp);
    program_code <= 8'h06;
    key(6);
    w(4);
    chk("standby", 1, standby_lamp);
    key(6);
    w(8);
    chk("standby", 0, standby_lamp);
    chk("routine", 1, n_rte);
    program_code <= 8'h00;
    key(6);
    w(3);
    chk("proceed", 1, n_pro);
    chk("software_alarm_lamp", 8'h00, software_alarm_lamp_field);
    // commit answering a please-perform request must not execute
    please_perform <= 1'b1;
    key(7);
    w(3);
    chk("perform", 1, n_ack);
    chk("exec", 2, n_exe);
    end_sim();
  end
endmodule // opk_panel_tb_top

`default_nettype wire
